// ==== design/flash_op_control_reg.sv ====
// Flash operation control register with AHB-Lite slave and interrupt
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module flash_op_control_reg (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire flash_ctl_pkg::engine_rsp_t engine_rsp_i,
    output flash_ctl_pkg::engine_cmd_t engine_cmd_o,
    output flash_ctl_pkg::op_kind_t engine_kind_o,
    output logic irq_o
);

    // Held control fields
    logic go_r;
    logic unlock_r;
    logic seq_err_r;
    logic erase_sel_r;
    logic [3:0] opsel_r;
    logic [flash_ctl_pkg::IRQ_W-1:0] irq_status_r;
    logic [flash_ctl_pkg::IRQ_W-1:0] irq_mask_r;

    // Registered address phase
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;

    // Decoded command state
    flash_ctl_pkg::op_kind_t kind_nxt;

    logic addr_phase;
    logic [15:0] ctl_wdata;
    logic ctl_write;
    logic go_request;
    logic go_ok;
    logic go_bad;
    logic [15:0] ctl_read;
    logic [flash_ctl_pkg::IRQ_W-1:0] irq_event;

    // Address phase taken when selected, nonsequential and bus ready
    assign addr_phase = hsel_i && hready_i &&
                        (htrans_i == flash_ctl_pkg::HTRANS_NONSEQ);
    assign ctl_wdata = hwdata_i[15:0];
    assign ctl_write = wr_pend_r && (addr_r == flash_ctl_pkg::ADDR_CONTROL);

    // A go request is a write of one to go while idle
    assign go_request = ctl_write && ctl_wdata[flash_ctl_pkg::BIT_GO] &&
                        !go_r;
    // Unlock is the value held before this write, so one write cannot
    // both unlock and launch; software unlocks first.
    assign go_ok = go_request && unlock_r;
    assign go_bad = go_request && !unlock_r;

    // Decode of the command that the write carries
    flash_op_decode u_decode (
        .erase_sel_i(ctl_wdata[flash_ctl_pkg::BIT_ERASE_SEL]),
        .operation_select_i(ctl_wdata[3:0]),
        .kind_o(kind_nxt)
    );

    // Read view of the control register; unused bits tie low
    always_comb begin
        ctl_read = 16'h0000;
        ctl_read[flash_ctl_pkg::BIT_GO] = go_r;
        ctl_read[flash_ctl_pkg::BIT_UNLOCK] = unlock_r;
        ctl_read[flash_ctl_pkg::BIT_SEQ_ERR] = seq_err_r;
        ctl_read[flash_ctl_pkg::BIT_ERASE_SEL] = erase_sel_r;
        ctl_read[3:0] = opsel_r;
    end

    // Bus address phase capture; every transfer completes in one wait-free
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_phase && hwrite_i;
            rd_pend_r <= addr_phase && !hwrite_i;
            if (addr_phase) begin
                addr_r <= haddr_i;
            end
        end
    end

    // Zero wait states and OKAY only
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // Read data registered at address phase, so it stands in data phase
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (addr_phase && !hwrite_i) begin
            unique case (haddr_i)
                flash_ctl_pkg::ADDR_CONTROL:
                    hrdata_o <= {16'h0000, ctl_read};
                flash_ctl_pkg::ADDR_IRQ_STATUS:
                    hrdata_o <= {30'h0, irq_status_r};
                flash_ctl_pkg::ADDR_IRQ_MASK:
                    hrdata_o <= {30'h0, irq_mask_r};
                default:
                    hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Software-owned fields; frozen while an operation runs
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            unlock_r <=
                flash_ctl_pkg::CONTROL_RESET[flash_ctl_pkg::BIT_UNLOCK];
            erase_sel_r <= 1'b0;
            opsel_r <= 4'h0;
        end else if (ctl_write && !go_r) begin
            unlock_r <= ctl_wdata[flash_ctl_pkg::BIT_UNLOCK];
            erase_sel_r <= ctl_wdata[flash_ctl_pkg::BIT_ERASE_SEL];
            opsel_r <= ctl_wdata[3:0];
        end
    end

    // Go bit: set by an accepted start, cleared by the engine on done or fault
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            go_r <= 1'b0;
        end else if (go_ok) begin
            go_r <= 1'b1;
        end else if (go_r && (engine_rsp_i.done || engine_rsp_i.fault)) begin
            go_r <= 1'b0;
        end
    end

    // Error flag is hardware driven only; writing its bit has no effect, but a go write sets it while locked and clears it when accepted
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            seq_err_r <= 1'b0;
        end else if (go_bad) begin
            seq_err_r <= 1'b1;
        end else if (go_r && engine_rsp_i.fault) begin
            seq_err_r <= 1'b1;
        end else if (go_ok) begin
            seq_err_r <= 1'b0;
        end
    end

    // Engine command outputs, all from flops
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            engine_cmd_o <= '0;
            engine_kind_o <= flash_ctl_pkg::OPK_NONE;
        end else begin
            engine_cmd_o.go <= go_ok ||
                (go_r && !(engine_rsp_i.done || engine_rsp_i.fault));
            if (go_ok) begin
                engine_cmd_o.erase_sel <=
                    ctl_wdata[flash_ctl_pkg::BIT_ERASE_SEL];
                engine_cmd_o.operation_select <= ctl_wdata[3:0];
                engine_kind_o <= kind_nxt;
            end else if (!go_r) begin
                engine_kind_o <= flash_ctl_pkg::OPK_NONE;
            end
        end
    end

    // Interrupt events: completion and sequence error
    always_comb begin
        irq_event = '0;
        irq_event[flash_ctl_pkg::IRQ_DONE] = go_r && engine_rsp_i.done;
        irq_event[flash_ctl_pkg::IRQ_ERR] = go_bad ||
                                            (go_r && engine_rsp_i.fault);
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_status_r <= flash_ctl_pkg::IRQ_RESET;
        end else if (wr_pend_r &&
                     addr_r == flash_ctl_pkg::ADDR_IRQ_STATUS) begin
            irq_status_r <= (irq_status_r & ~hwdata_i[1:0]) | irq_event;
        end else begin
            irq_status_r <= irq_status_r | irq_event;
        end
    end

    // Mask register
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_mask_r <= flash_ctl_pkg::IRQ_RESET;
        end else if (wr_pend_r && addr_r == flash_ctl_pkg::ADDR_IRQ_MASK) begin
            irq_mask_r <= hwdata_i[1:0];
        end
    end

    // Interrupt lags status by one cycle to come from a flop
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status_r & irq_mask_r);
        end
    end

    // A start while locked never reaches the engine
    sequence s_locked_go;
        go_bad;
    endsequence

    AST_LOCKED_NO_START: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_locked_go |=> !engine_cmd_o.go && !go_r)
        else $error("go accepted while locked");

    AST_LOCKED_SETS_ERR: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_locked_go |=> seq_err_r)
        else $error("locked go did not set error");

    AST_ERR_ONLY_HW: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(seq_err_r) |->
        $past(go_bad) || $past(go_r && engine_rsp_i.fault))
        else $error("error flag rose without cause");

    AST_GOOD_START_CLEARS_ERR: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        go_ok |=> !seq_err_r && go_r)
        else $error("normal start left error set");

    AST_UNUSED_ZERO: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        rd_pend_r && addr_r == flash_ctl_pkg::ADDR_CONTROL |->
        hrdata_o[12:7] == 6'h00 && hrdata_o[5:4] == 2'h0)
        else $error("unimplemented bits read nonzero");

    AST_UNLOCKED_START: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        go_request && unlock_r |=> engine_cmd_o.go)
        else $error("unlocked go not started");

    AST_DONE_CLEARS_GO: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        go_r && engine_rsp_i.done |=> !go_r ##1 !engine_cmd_o.go)
        else $error("go not cleared on completion");

    AST_PROGRAM_WORD: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        go_ok && !ctl_wdata[flash_ctl_pkg::BIT_ERASE_SEL] &&
        ctl_wdata[3:0] == flash_ctl_pkg::OP_PROGRAM_WORD |=>
        engine_kind_o == flash_ctl_pkg::OPK_PROGRAM_WORD)
        else $error("program code 0011 not decoded");

    AST_ERASE_CODES: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        go_ok && ctl_wdata[flash_ctl_pkg::BIT_ERASE_SEL] &&
        ctl_wdata[3:0] == flash_ctl_pkg::OP_ERASE_PAGE |=>
        engine_kind_o == flash_ctl_pkg::OPK_ERASE_PAGE)
        else $error("page erase not decoded");

    AST_NOOP_CODE: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        go_ok && ctl_wdata[3:0] == 4'hF |=>
        engine_kind_o == flash_ctl_pkg::OPK_NONE)
        else $error("code 1111 not a no-op");

endmodule

// ==== pkg/flash_ctl_pkg.sv ====
// Package: register map, field layout and operation codes for flash control
package flash_ctl_pkg;

    // Byte addresses of the word registers
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;

    // Control register field positions
    localparam int BIT_GO = 15;
    localparam int BIT_UNLOCK = 14;
    localparam int BIT_SEQ_ERR = 13;
    localparam int BIT_ERASE_SEL = 6;
    localparam int OPSEL_LSB = 0;
    localparam int OPSEL_W = 4;

    // Interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_W = 2;

    // Reset values
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // Operation-select encodings
    localparam logic [3:0] OP_ERASE_SEGMENT = 4'hD;
    localparam logic [3:0] OP_ERASE_PAGE = 4'h2;
    localparam logic [3:0] OP_PROGRAM_WORD = 4'h3;

    // AHB transfer type and size
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Operation kinds passed to the timing engine
    typedef enum logic [1:0] {
        OPK_NONE = 2'b00,
        OPK_ERASE_SEGMENT = 2'b01,
        OPK_ERASE_PAGE = 2'b10,
        OPK_PROGRAM_WORD = 2'b11
    } op_kind_t;

    // Command to the timing engine
    typedef struct packed {
        logic go;
        logic erase_sel;
        logic [3:0] operation_select;
    } engine_cmd_t;

    // Report from the timing engine
    typedef struct packed {
        logic done;
        logic fault;
    } engine_rsp_t;

endpackage

// ==== design/flash_op_decode.sv ====
// Decoder from erase select and operation select to an operation kind
`timescale 1ns/1ps
module flash_op_decode (
    input wire logic erase_sel_i,
    input wire logic [3:0] operation_select_i,
    output flash_ctl_pkg::op_kind_t kind_o
);

    // Only three codes launch anything; all others are no operation
    always_comb begin
        kind_o = flash_ctl_pkg::OPK_NONE;
        if (erase_sel_i) begin
            if (operation_select_i == flash_ctl_pkg::OP_ERASE_SEGMENT) begin
                kind_o = flash_ctl_pkg::OPK_ERASE_SEGMENT;
            end else if (operation_select_i ==
                         flash_ctl_pkg::OP_ERASE_PAGE) begin
                kind_o = flash_ctl_pkg::OPK_ERASE_PAGE;
            end
        end else if (operation_select_i ==
                     flash_ctl_pkg::OP_PROGRAM_WORD) begin
            kind_o = flash_ctl_pkg::OPK_PROGRAM_WORD;
        end
    end

endmodule

// ==== testbench/flash_op_control_reg_tb_top.sv ====
// Self-checking bench for the flash operation control register
`timescale 1ns/1ps
module flash_op_control_reg_tb_top;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [7:0] haddr_i = 8'h00;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h00000000;
    logic [31:0] hrdata_o;
    logic [31:0] rd;
    logic hreadyout_o;
    logic hresp_o;
    logic irq_o;
    flash_ctl_pkg::engine_rsp_t engine_rsp_i = 2'h0;
    flash_ctl_pkg::engine_cmd_t engine_cmd_o;
    flash_ctl_pkg::op_kind_t engine_kind_o;
    int fails = 0;
    int comparisons = 0;

    // Single slave, so its ready is the bus ready
    flash_op_control_reg flash_op_control_reg_i (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .engine_rsp_i(engine_rsp_i), .engine_cmd_o(engine_cmd_o),
        .engine_kind_o(engine_kind_o), .irq_o(irq_o)
    );

    // 50 ns period
    always #25 core_clk_i = ~core_clk_i;

    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: word %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: bit %b not %b", $time, got, exp);
        end
    endtask

    task automatic chk_kind(input flash_ctl_pkg::op_kind_t got,
                            input flash_ctl_pkg::op_kind_t exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: kind %0d not %0d", $time, got, exp);
        end
    endtask

    // One AHB single transfer; waits on ready, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd);
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= flash_ctl_pkg::HTRANS_NONSEQ;
        haddr_i <= a;
        hwrite_i <= w;
        hsize_i <= flash_ctl_pkg::HSIZE_WORD;
        @(posedge core_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        @(posedge core_clk_i);
        while (hreadyout_o !== 1'b1) @(posedge core_clk_i);
        rd = hrdata_o;
        chk_bit(hresp_o, 1'b0);
    endtask

    // Engine report pulse, then let go settle
    task automatic pulse(input logic [1:0] r);
        @(posedge core_clk_i);
        engine_rsp_i <= r;
        @(posedge core_clk_i);
        engine_rsp_i <= 2'h0;
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    task automatic test_reset;
        xfer(1'b0, flash_ctl_pkg::ADDR_CONTROL, 32'h0);
        chk_word(rd, 32'h00000000);
        xfer(1'b0, flash_ctl_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk_word(rd, 32'h00000000);
        chk_bit(irq_o, 1'b0);
        xfer(1'b1, 8'h0C, 32'hFFFFFFFF);
        xfer(1'b0, 8'h0C, 32'h0);
        chk_word(rd, 32'h00000000);
    endtask

    // Go while locked: refused, error flag raised, interrupt path
    task automatic test_locked_go;
        xfer(1'b1, flash_ctl_pkg::ADDR_CONTROL, 32'h0000004D);
        xfer(1'b1, flash_ctl_pkg::ADDR_CONTROL, 32'h0000804D);
        @(negedge core_clk_i);
        chk_bit(engine_cmd_o.go, 1'b0);
        xfer(1'b0, flash_ctl_pkg::ADDR_CONTROL, 32'h0);
        chk_word(rd & 32'h0000E000, 32'h00002000);
        xfer(1'b1, flash_ctl_pkg::ADDR_CONTROL, 32'h00000000);
        xfer(1'b0, flash_ctl_pkg::ADDR_CONTROL, 32'h0);
        chk_word(rd & 32'h0000E000, 32'h00002000);
        xfer(1'b0, flash_ctl_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk_word(rd, 32'h00000002);
        // Only the done bit unmasked: error must stay quiet
        xfer(1'b1, flash_ctl_pkg::ADDR_IRQ_MASK, 32'h00000001);
        repeat (2) @(negedge core_clk_i);
        chk_bit(irq_o, 1'b0);
        xfer(1'b1, flash_ctl_pkg::ADDR_IRQ_MASK, 32'h00000002);
        repeat (2) @(negedge core_clk_i);
        chk_bit(irq_o, 1'b1);
        xfer(1'b1, flash_ctl_pkg::ADDR_IRQ_STATUS, 32'h00000002);
        repeat (2) @(negedge core_clk_i);
        chk_bit(irq_o, 1'b0);
        xfer(1'b1, flash_ctl_pkg::ADDR_IRQ_MASK, 32'h00000003);
    endtask

    // Every erase and program code, plus unassigned ones
    task automatic test_ops;
        logic [15:0] ctl [5] = '{16'h004D, 16'h0042, 16'h0003,
                                 16'h000F, 16'h004F};
        flash_ctl_pkg::op_kind_t kd [5] = '{
            flash_ctl_pkg::OPK_ERASE_SEGMENT, flash_ctl_pkg::OPK_ERASE_PAGE,
            flash_ctl_pkg::OPK_PROGRAM_WORD, flash_ctl_pkg::OPK_NONE,
            flash_ctl_pkg::OPK_NONE};
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, flash_ctl_pkg::ADDR_CONTROL,
                 {16'h0, 16'h4000 | ctl[i]});
            xfer(1'b1, flash_ctl_pkg::ADDR_CONTROL,
                 {16'h0, 16'hC000 | ctl[i]});
            @(negedge core_clk_i);
            chk_bit(engine_cmd_o.go, 1'b1);
            chk_kind(engine_kind_o, kd[i]);
            chk_bit(engine_cmd_o.erase_sel, ctl[i][6]);
            chk_word({28'h0, engine_cmd_o.operation_select},
                     {28'h0, ctl[i][3:0]});
            xfer(1'b0, flash_ctl_pkg::ADDR_CONTROL, 32'h0);
            chk_word(rd, {16'h0, 16'hC000 | ctl[i]});
            pulse(2'b10);
            chk_bit(engine_cmd_o.go, 1'b0);
            xfer(1'b0, flash_ctl_pkg::ADDR_CONTROL, 32'h0);
            chk_word(rd, {16'h0, 16'h4000 | ctl[i]});
            chk_bit(irq_o, 1'b1);
            xfer(1'b1, flash_ctl_pkg::ADDR_IRQ_STATUS, 32'h00000001);
        end
        // Every writable bit but go high: holes read back as zero
        xfer(1'b1, flash_ctl_pkg::ADDR_CONTROL, 32'hFFFF7FFF);
        xfer(1'b0, flash_ctl_pkg::ADDR_CONTROL, 32'h0);
        chk_word(rd, 32'h0000404F);
    endtask

    // Engine fault counts as an improper termination
    task automatic test_fault;
        xfer(1'b1, flash_ctl_pkg::ADDR_CONTROL, 32'h00004003);
        xfer(1'b1, flash_ctl_pkg::ADDR_CONTROL, 32'h0000C003);
        pulse(2'b01);
        chk_bit(engine_cmd_o.go, 1'b0);
        xfer(1'b0, flash_ctl_pkg::ADDR_CONTROL, 32'h0);
        chk_word(rd, 32'h00006003);
        xfer(1'b0, flash_ctl_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk_word(rd, 32'h00000002);
    endtask

    // Whole run is about two hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        test_reset();
        test_locked_go();
        test_ops();
        test_fault();
        wrap_up();
    end
endmodule
